// ===== dv/ipt_far_model.sv
module ipt_far_model #(
   parameter int N = 240
) (
   input wire logic ref_clk_i,
   output logic [N-1:0] req_o,
   output logic enter_o,
   output logic [8:0] enter_num_o,
   output logic ret_o,
   output logic [8:0] ret_num_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      req_o <= '0;
      enter_o <= 1'b0;
      ret_o <= 1'b0;
      enter_num_o <= '0;
      ret_num_o <= '0;
   end
   // one full cycle high, the shortest pulse that must still be caught
   task automatic pulse(input int n);
      @(posedge ref_clk_i);
      req_o[n] <= 1'b1;
      @(posedge ref_clk_i);
      req_o[n] <= 1'b0;
   endtask : pulse
   task automatic level(input int n, input logic v);
      @(posedge ref_clk_i);
      req_o[n] <= v;
   endtask : level
   // released numbers show the inverse so a stale value cannot match
   task automatic enter(input logic [8:0] n);
      @(posedge ref_clk_i);
      enter_o <= 1'b1;
      enter_num_o <= n;
      @(posedge ref_clk_i);
      enter_o <= 1'b0;
      enter_num_o <= ~n;
   endtask : enter
   task automatic leave(input logic [8:0] n);
      @(posedge ref_clk_i);
      ret_o <= 1'b1;
      ret_num_o <= n;
      @(posedge ref_clk_i);
      ret_o <= 1'b0;
      ret_num_o <= ~n;
   endtask : leave
endmodule : ipt_far_model

// ===== dv/ipt_top_sva.sv
`include "ipt_cfg.svh"

module ipt_top_chk
   import ipt_pkg::*;
#(
   parameter int N = 240
) (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic [N-1:0] irq_req_i,
   input wire logic core_enter_i,
   input wire logic [8:0] core_enter_num_i,
   input wire logic core_return_i,
   input wire logic [8:0] core_return_num_i,
   input wire logic [11:0] bus_addr_i,
   input wire logic [31:0] bus_wdata_i,
   input wire logic bus_wr_i,
   input wire logic bus_rd_i,
   input wire logic bus_priv_i,
   input wire logic [31:0] bus_rdata_o,
   input wire logic take_valid_o,
   input wire logic [8:0] take_num_o,
   input wire logic pending_any_o
);
   default clocking dc @(posedge ref_clk_i);
   endclocking
   default disable iff (!reset_n_i);
   logic trig;
   assign trig = bus_wr_i && bus_priv_i && bus_addr_i == `IPT_OFS_SW_TRIG;

   trig_pend_a: assert property (
      trig && bus_wdata_i[8:0] < N |-> ##[1:2] pending_any_o)
      else $error("trigger write left nothing pending");
   edge_pend_a: assert property (
      |(irq_req_i & ~$past(irq_req_i)) |-> ##[1:2] pending_any_o)
      else $error("request edge left nothing pending");
   offer_pend_a: assert property (take_valid_o |-> pending_any_o)
      else $error("offer without pending interrupt");
   enter_drop_a: assert property (
      core_enter_i && core_enter_num_i < N |-> ##2
      !(take_valid_o && take_num_o == $past(core_enter_num_i, 2)))
      else $error("entered interrupt still offered");
   rd_idle_a: assert property (!$past(bus_rd_i) |-> bus_rdata_o == '0)
      else $error("read data outside its cycle");
   unpriv_rd_a: assert property (
      $past(bus_rd_i && !bus_priv_i) |-> bus_rdata_o == '0)
      else $error("unprivileged read returned data");
   take_zero_a: assert property (!take_valid_o |-> take_num_o == '0)
      else $error("offer number without offer");
   reset_quiet_a: assert property (!$past(reset_n_i) |->
      !take_valid_o && !pending_any_o && bus_rdata_o == '0)
      else $error("outputs active right after reset");
   cover property (trig);
   cover property (core_return_i);
   cover property ($rose(take_valid_o));
endmodule : ipt_top_chk

bind ipt_top ipt_top_chk #(.N(N)) u_ipt_top_chk (
   .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .irq_req_i(irq_req_i),
   .core_enter_i(core_enter_i), .core_enter_num_i(core_enter_num_i),
   .core_return_i(core_return_i), .core_return_num_i(core_return_num_i),
   .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i),
   .bus_rd_i(bus_rd_i), .bus_priv_i(bus_priv_i), .bus_rdata_o(bus_rdata_o),
   .take_valid_o(take_valid_o), .take_num_o(take_num_o),
   .pending_any_o(pending_any_o));

// ===== dv/ipt_top_test.sv
`include "ipt_cfg.svh"

module ipt_top_test
   import ipt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] SP = `IPT_OFS_SET_PEND;
   localparam logic [11:0] CP = `IPT_OFS_CLR_PEND;
   localparam logic [11:0] AC = `IPT_OFS_ACTIVE;
   localparam logic [11:0] TR = `IPT_OFS_SW_TRIG;
   localparam logic [11:0] SC = `IPT_OFS_SYS_CTRL;
   logic ref_clk_i, reset_n_i, bus_wr_i, bus_rd_i, bus_priv_i;
   logic [11:0] bus_addr_i;
   ipt_word_t bus_wdata_i, bus_rdata_o;
   logic take_valid_o, pending_any_o, ent, ret;
   logic [8:0] take_num_o, ent_num, ret_num;
   logic [239:0] req;
   int n_mismatch = 0;
   int num_checks = 0;

   ipt_top u_ipt_top (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
      .irq_req_i(req), .core_enter_i(ent), .core_enter_num_i(ent_num),
      .core_return_i(ret), .core_return_num_i(ret_num),
      .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i),
      .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_priv_i(bus_priv_i),
      .bus_rdata_o(bus_rdata_o), .take_valid_o(take_valid_o),
      .take_num_o(take_num_o), .pending_any_o(pending_any_o));
   ipt_far_model u_ipt_far_model (.ref_clk_i(ref_clk_i), .req_o(req),
      .enter_o(ent), .enter_num_o(ent_num), .ret_o(ret),
      .ret_num_o(ret_num));

   initial begin
      ref_clk_i = 1'b0;
      forever #10 ref_clk_i = ~ref_clk_i;
   end

   // ----------------------------------------------------------------
   // bus access and compare
   // ----------------------------------------------------------------
   task automatic chk(input ipt_word_t seen, input ipt_word_t exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input ipt_word_t d,
                     input logic p = 1'b1);
      @(posedge ref_clk_i);
      bus_wr_i <= 1'b1;
      bus_addr_i <= a;
      bus_wdata_i <= d;
      bus_priv_i <= p;
      @(posedge ref_clk_i);
      bus_wr_i <= 1'b0;
   endtask : wr
   task automatic rdc(input logic [11:0] a, input ipt_word_t exp,
                      input logic p = 1'b1);
      @(posedge ref_clk_i);
      bus_rd_i <= 1'b1;
      bus_addr_i <= a;
      bus_priv_i <= p;
      @(posedge ref_clk_i);
      bus_rd_i <= 1'b0;
      #1 chk(bus_rdata_o, exp);
   endtask : rdc
   task automatic tkc(input logic v, input logic [8:0] n);
      repeat (2) @(posedge ref_clk_i);
      #1 chk({22'h0, take_valid_o, take_num_o}, {22'h0, v, n});
   endtask : tkc
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude

   initial begin
      repeat (5000) @(posedge ref_clk_i);
      n_mismatch++;
      conclude();
   end

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      reset_n_i <= 1'b0;
      bus_wr_i <= 1'b0;
      bus_rd_i <= 1'b0;
      bus_priv_i <= 1'b1;
      bus_addr_i <= '0;
      bus_wdata_i <= '0;
      repeat (5) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      rdc(`IPT_OFS_TYPE, 32'h0000_0000);
      rdc(SC, 32'h0000_0000);
      rdc(12'h100, 32'h0000_0000);
      wr(`IPT_OFS_SET_EN, 32'hFFFF_FFFF);
      wr(`IPT_OFS_TYPE, 32'h0000_0080);
      wr(TR, 32'h0000_0005);
      tkc(1'b1, 9'h005);
      rdc(SP, 32'h0000_0020);
      rdc(SP, 32'h0000_0000, 1'b0);
      wr(`IPT_OFS_CLR_EN, 32'h0000_0020);
      tkc(1'b0, 9'h000);
      rdc(SP, 32'h0000_0020);
      wr(`IPT_OFS_SET_EN, 32'h0000_0020);
      wr(CP, 32'h0000_0020);
      wr(TR, 32'h0000_0006, 1'b0);
      wr(SC, 32'h0000_0002, 1'b0);
      wr(TR, 32'h0000_0006, 1'b0);
      rdc(SP, 32'h0000_0000);
      wr(SC, 32'h0000_0002);
      wr(TR, 32'h0000_0006, 1'b0);
      rdc(SP, 32'h0000_0040);
      rdc(TR, 32'h0000_0000);
      wr(CP, 32'hFFFF_FFFF);
      wr(TR, 32'hFFFF_FE08);
      rdc(SP, 32'h0000_0100);
      wr(CP, 32'h0000_0100);
      wr(TR, 32'h0000_00F0);
      tkc(1'b0, 9'h000);
      chk({31'h0, pending_any_o}, 32'h0000_0000);
      u_ipt_far_model.level(3, 1'b1);
      tkc(1'b1, 9'h003);
      u_ipt_far_model.enter(3);
      rdc(SP, 32'h0000_0000);
      rdc(AC, 32'h0000_0008);
      u_ipt_far_model.leave(3);
      rdc(SP, 32'h0000_0008);
      wr(CP, 32'h0000_0008);
      rdc(SP, 32'h0000_0008);
      u_ipt_far_model.level(3, 1'b0);
      wr(CP, 32'h0000_0008);
      rdc(SP, 32'h0000_0000);
      u_ipt_far_model.level(3, 1'b1);
      tkc(1'b1, 9'h003);
      u_ipt_far_model.enter(3);
      u_ipt_far_model.level(3, 1'b0);
      u_ipt_far_model.leave(3);
      rdc(SP, 32'h0000_0000);
      rdc(AC, 32'h0000_0000);
      u_ipt_far_model.pulse(7);
      rdc(SP, 32'h0000_0080);
      u_ipt_far_model.enter(7);
      u_ipt_far_model.pulse(7);
      rdc(SP, 32'h0000_0080);
      rdc(AC, 32'h0000_0080);
      wr(CP, 32'h0000_0080);
      rdc(SP, 32'h0000_0000);
      rdc(AC, 32'h0000_0080);
      u_ipt_far_model.pulse(7);
      u_ipt_far_model.leave(7);
      rdc(SP, 32'h0000_0080);
      u_ipt_far_model.enter(7);
      u_ipt_far_model.leave(7);
      rdc(SP, 32'h0000_0000);
      rdc(AC, 32'h0000_0000);
      u_ipt_far_model.pulse(7);
      wr(CP, 32'h0000_0080);
      rdc(SP, 32'h0000_0000);
      // top word: bits above the last interrupt stay zero
      wr(SP + 12'h01C, 32'hFFFF_FFFF);
      rdc(SP + 12'h01C, 32'h0000_FFFF);
      wr(CP + 12'h01C, 32'hFFFF_FFFF);
      rdc(SP + 12'h01C, 32'h0000_0000);
      wr(`IPT_OFS_SET_EN + 12'h01C, 32'h0000_8000);
      wr(TR, 32'h0000_00EF);
      tkc(1'b1, 9'h0EF);
      u_ipt_far_model.enter(9'h0EF);
      rdc(AC + 12'h01C, 32'h0000_8000);
      u_ipt_far_model.leave(9'h0EF);
      rdc(AC + 12'h01C, 32'h0000_0000);
      u_ipt_far_model.enter(9'h1FF);
      rdc(AC + 12'h01C, 32'h0000_0000);
      tkc(1'b0, 9'h000);
      // second reset in mid-run must clear every register
      wr(SP, 32'h0000_0010);
      @(posedge ref_clk_i);
      reset_n_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      rdc(SP, 32'h0000_0000);
      rdc(SC, 32'h0000_0000);
      rdc(`IPT_OFS_SET_EN, 32'h0000_0000);
      rdc(`IPT_OFS_TYPE, 32'h0000_0000);
      chk({31'h0, pending_any_o}, 32'h0000_0000);
      conclude();
   end
endmodule : ipt_top_test

// ===== hw/ipt_cfg.svh
`ifndef IPT_CFG_SVH
`define IPT_CFG_SVH
// Functional notes
// - software trigger write makes the numbered interrupt (bits 8:0) pending
// - unprivileged trigger writes honoured only while user trigger permit is 1
// - user trigger permit changes only on privileged writes
// - pulse inputs sampled each rising clock edge, detected pulse latched
// - entering the service routine clears pending and sets active
// - level request high while not active makes the interrupt pending
// - rising edge on the request line makes the interrupt pending
// - set-pending bit write or trigger write makes the interrupt pending
// - level return: request high gives pending again, else inactive
// - pulse during service gives active and pending, pending after return
// - pulse with no new pulse during service returns to inactive
// - level clear-pending ignored while request high, else inactive
// - pulse clear-pending: pending to inactive, active-pending to active
// - disabled interrupts may still become pending
// - only enabled pending interrupts are offered to the core
// - clear-pending never alters the active state

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define IPT_OFS_SET_EN 12'h000
`define IPT_OFS_CLR_EN 12'h020
`define IPT_OFS_SET_PEND 12'h040
`define IPT_OFS_CLR_PEND 12'h060
`define IPT_OFS_ACTIVE 12'h080
`define IPT_OFS_TYPE 12'h0a0
`define IPT_OFS_SYS_CTRL 12'h0c0
`define IPT_OFS_SW_TRIG 12'h0c4

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define IPT_PERMIT_BIT 1
`define IPT_NUM_MSB 8
`define IPT_NUM_IRQ 240
`define IPT_WORDS 8
`define IPT_RST_WORD 32'h0000_0000
`endif

// ===== hw/ipt_irq_state.sv
module ipt_irq_state
   import ipt_pkg::*;
#(
   parameter int N = 240
) (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   ipt_state_if.state st
);
   logic [N-1:0] req_prev_reg;
   logic [N-1:0] pend_reg;
   logic [N-1:0] act_reg;
   logic [N-1:0] rise;
   logic [N-1:0] lvl_set;
   logic [N-1:0] set_ev;
   logic [N-1:0] clr_ev;
   logic [N-1:0] pend_next;
   logic [N-1:0] act_next;

   // ----------------------------------------------------------------
   // event detection
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         req_prev_reg <= '0;
      end else begin
         req_prev_reg <= st.req;
      end
   end

   always_comb begin
      rise = st.req & ~req_prev_reg;
      // a level request re-arms on return; blocked while entering
      lvl_set = ~st.is_pulse & st.req & ~st.enter
         & (~act_reg | st.ret);
      set_ev = lvl_set | rise | st.sw_set;
      // level clear only bites once the line has dropped
      clr_ev = st.enter
         | (st.sw_clr & (st.is_pulse | ~st.req));
      // set wins over clear in the same cycle
      pend_next = (pend_reg & ~clr_ev) | set_ev;
      act_next = (act_reg & ~st.ret) | st.enter;
   end

   // ----------------------------------------------------------------
   // state flops
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         pend_reg <= '0;
         act_reg <= '0;
      end else begin
         pend_reg <= pend_next;
         act_reg <= act_next;
      end
   end

   assign st.pending = pend_reg;
   assign st.active = act_reg;
endmodule : ipt_irq_state

// ===== hw/ipt_pkg.sv
package ipt_pkg;
   typedef logic [8:0] ipt_num_t;
   typedef logic [31:0] ipt_word_t;
   typedef logic [255:0] ipt_vec_t;
endpackage : ipt_pkg

// ===== hw/ipt_state_if.sv
interface ipt_state_if #(
   parameter int N = 240
);
   logic [N-1:0] req;
   logic [N-1:0] is_pulse;
   logic [N-1:0] sw_set;
   logic [N-1:0] sw_clr;
   logic [N-1:0] enter;
   logic [N-1:0] ret;
   logic [N-1:0] pending;
   logic [N-1:0] active;
   modport ctrl (
      output req, is_pulse, sw_set, sw_clr, enter, ret,
      input pending, active
   );
   modport state (
      input req, is_pulse, sw_set, sw_clr, enter, ret,
      output pending, active
   );
endinterface : ipt_state_if

// ===== hw/ipt_top.sv
`include "ipt_cfg.svh"

module ipt_top
   import ipt_pkg::*;
#(
   parameter int N = `IPT_NUM_IRQ
) (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic [N-1:0] irq_req_i,
   input wire logic core_enter_i,
   input wire logic [8:0] core_enter_num_i,
   input wire logic core_return_i,
   input wire logic [8:0] core_return_num_i,
   input wire logic [11:0] bus_addr_i,
   input wire logic [31:0] bus_wdata_i,
   input wire logic bus_wr_i,
   input wire logic bus_rd_i,
   input wire logic bus_priv_i,
   output logic [31:0] bus_rdata_o,
   output logic take_valid_o,
   output logic [8:0] take_num_o,
   output logic pending_any_o
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic ipt_vec_t ipt_place(input logic [2:0] idx,
                                          input ipt_word_t d);
      ipt_place = ipt_vec_t'(d) << {idx, 5'b0_0000};
   endfunction : ipt_place

   function automatic ipt_word_t ipt_pick(input ipt_vec_t v,
                                          input logic [2:0] idx);
      ipt_pick = v[{idx, 5'b0_0000} +: 32];
   endfunction : ipt_pick

   function automatic logic [N-1:0] ipt_onehot(input ipt_num_t num);
      ipt_vec_t v;
      v = ipt_vec_t'(1) << num;
      ipt_onehot = (num < ipt_num_t'(N)) ? v[N-1:0] : '0;
   endfunction : ipt_onehot

   function automatic ipt_vec_t ipt_pad(input logic [N-1:0] v);
      ipt_pad = ipt_vec_t'(v);
   endfunction : ipt_pad

   function automatic logic ipt_hit(input logic [11:0] base,
                                    input logic [11:0] addr);
      ipt_hit = {addr[11:5], 5'b0_0000} == base;
   endfunction : ipt_hit

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic [N-1:0] enable_reg;
   logic [N-1:0] type_reg;
   logic permit_reg;
   logic [31:0] rdata_reg;
   logic take_valid_reg;
   logic [8:0] take_num_reg;
   logic pend_any_reg;

   logic [N-1:0] en_set;
   logic [N-1:0] en_clr;
   logic [N-1:0] pend_set;
   logic [N-1:0] pend_clr;
   logic [N-1:0] trig_set;
   logic type_wr;
   logic permit_wr;
   logic [2:0] word_idx;
   logic [31:0] rdata_next;
   ipt_vec_t type_new;
   logic [N-1:0] cand;
   logic cand_any;
   logic [8:0] cand_num;

   ipt_state_if #(.N(N)) st_if ();

   ipt_irq_state #(.N(N)) u_state (
      .ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i),
      .st(st_if.state)
   );

   assign word_idx = bus_addr_i[4:2];

   // ----------------------------------------------------------------
   // write decode
   // ----------------------------------------------------------------
   // low address bits of the banked registers are not checked: callers must align accesses
   always_comb begin
      ipt_vec_t w;
      w = ipt_place(word_idx, bus_wdata_i);
      type_new = (ipt_pad(type_reg)
         & ~ipt_place(word_idx, 32'hffff_ffff)) | w;
      en_set = '0;
      en_clr = '0;
      pend_set = '0;
      pend_clr = '0;
      trig_set = '0;
      type_wr = 1'b0;
      permit_wr = 1'b0;
      if (bus_wr_i) begin
         if (bus_addr_i == `IPT_OFS_SW_TRIG) begin
            // unprivileged code reaches this only with permission
            if (bus_priv_i || permit_reg) begin
               trig_set = ipt_onehot(
                  bus_wdata_i[`IPT_NUM_MSB:0]);
            end
         end else if (!bus_priv_i) begin
            // every other register is privileged only
            en_set = '0;
         end else if (bus_addr_i == `IPT_OFS_SYS_CTRL) begin
            permit_wr = 1'b1;
         end else if (ipt_hit(`IPT_OFS_SET_EN, bus_addr_i)) begin
            en_set = w[N-1:0];
         end else if (ipt_hit(`IPT_OFS_CLR_EN, bus_addr_i)) begin
            en_clr = w[N-1:0];
         end else if (ipt_hit(`IPT_OFS_SET_PEND, bus_addr_i)) begin
            pend_set = w[N-1:0];
         end else if (ipt_hit(`IPT_OFS_CLR_PEND, bus_addr_i)) begin
            pend_clr = w[N-1:0];
         end else if (ipt_hit(`IPT_OFS_TYPE, bus_addr_i)) begin
            type_wr = 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         enable_reg <= '0;
      end else begin
         // enabling gates only the offer to the core, not pending
         enable_reg <= (enable_reg & ~en_clr) | en_set;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         type_reg <= '0;
      end else if (type_wr) begin
         // the padded bits above the last interrupt are dropped here
         type_reg <= type_new[N-1:0];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         permit_reg <= 1'b0;
      end else if (permit_wr) begin
         permit_reg <= bus_wdata_i[`IPT_PERMIT_BIT];
      end
   end

   // ----------------------------------------------------------------
   // hookup to the state cells
   // ----------------------------------------------------------------
   assign st_if.req = irq_req_i;
   assign st_if.is_pulse = type_reg;
   assign st_if.sw_set = pend_set | trig_set;
   assign st_if.sw_clr = pend_clr;
   assign st_if.enter = core_enter_i
      ? ipt_onehot(core_enter_num_i) : '0;
   assign st_if.ret = core_return_i
      ? ipt_onehot(core_return_num_i) : '0;

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   always_comb begin
      rdata_next = `IPT_RST_WORD;
      if (bus_rd_i && bus_priv_i) begin
         if (bus_addr_i == `IPT_OFS_SYS_CTRL) begin
            rdata_next[`IPT_PERMIT_BIT] = permit_reg;
         end else if (bus_addr_i == `IPT_OFS_SW_TRIG) begin
            rdata_next = `IPT_RST_WORD;
         end else if (ipt_hit(`IPT_OFS_SET_EN, bus_addr_i)
                      || ipt_hit(`IPT_OFS_CLR_EN, bus_addr_i)) begin
            rdata_next = ipt_pick(ipt_pad(enable_reg), word_idx);
         end else if (ipt_hit(`IPT_OFS_SET_PEND, bus_addr_i)
                      || ipt_hit(`IPT_OFS_CLR_PEND, bus_addr_i)) begin
            rdata_next = ipt_pick(ipt_pad(st_if.pending), word_idx);
         end else if (ipt_hit(`IPT_OFS_ACTIVE, bus_addr_i)) begin
            rdata_next = ipt_pick(ipt_pad(st_if.active), word_idx);
         end else if (ipt_hit(`IPT_OFS_TYPE, bus_addr_i)) begin
            rdata_next = ipt_pick(ipt_pad(type_reg), word_idx);
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         rdata_reg <= `IPT_RST_WORD;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // ----------------------------------------------------------------
   // offer to the core
   // ----------------------------------------------------------------
   // priority fields are kept elsewhere; lowest number wins here
   always_comb begin
      cand = st_if.pending & enable_reg & ~st_if.active;
      cand_any = |cand;
      cand_num = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (cand[i]) begin
            cand_num = 9'(i);
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         take_valid_reg <= 1'b0;
         take_num_reg <= '0;
      end else begin
         take_valid_reg <= cand_any;
         take_num_reg <= cand_num;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         pend_any_reg <= 1'b0;
      end else begin
         pend_any_reg <= |st_if.pending;
      end
   end

   assign bus_rdata_o = rdata_reg;
   assign take_valid_o = take_valid_reg;
   assign take_num_o = take_num_reg;
   assign pending_any_o = pend_any_reg;
endmodule : ipt_top
